// ### pkg/rtc_view_pkg.sv
package rtc_view_pkg;

  // Bus geometry
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_VALUE = 4'h1;

  // Control register field positions
  localparam int CTRL_PTR_LSB = 0;
  localparam int CTRL_PTR_W = 2;
  localparam int CTRL_WREN_BIT = 2;
  localparam int CTRL_EN_BIT = 3;
  localparam int CTRL_ERR_BIT = 4;

  // Control register reset values
  localparam logic [CTRL_PTR_W-1:0] PTR_RESET = 2'h0;
  localparam logic WREN_RESET = 1'b0;
  localparam logic EN_RESET = 1'b0;
  localparam logic ERR_RESET = 1'b0;
  localparam logic [DATA_W-1:0] RDATA_RESET = 16'h0000;

  // View pointer codes
  localparam logic [CTRL_PTR_W-1:0] PTR_MINSEC = 2'h0;
  localparam logic [CTRL_PTR_W-1:0] PTR_WDAYHR = 2'h1;

  // Digit table: weekday, hour tens, hour ones, minute tens,
  // minute ones, second tens, second ones
  localparam int NUM_DIGITS = 7;
  localparam int DIGIT_W = 4;
  localparam int DIG_LSB [NUM_DIGITS] = '{8, 4, 0, 12, 8, 4, 0};
  localparam int DIG_WID [NUM_DIGITS] = '{3, 2, 4, 3, 4, 3, 4};
  localparam int DIG_MAX [NUM_DIGITS] = '{6, 2, 9, 5, 9, 5, 9};
  localparam bit DIG_IN_WDAYHR [NUM_DIGITS] =
    '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};

  // Index of each digit in the table
  localparam int IDX_WEEKDAY_DIGIT = 0;
  localparam int IDX_HOUR_TENS_DIGIT = 1;
  localparam int IDX_HOUR_ONES_DIGIT = 2;
  localparam int IDX_MINUTE_TENS_DIGIT = 3;
  localparam int IDX_MINUTE_ONES_DIGIT = 4;
  localparam int IDX_SECOND_TENS_DIGIT = 5;
  localparam int IDX_SECOND_ONES_DIGIT = 6;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // Current time as stored digits
  typedef struct packed {
    logic [2:0] weekday_digit;
    logic [1:0] hour_tens_digit;
    logic [3:0] hour_ones_digit;
    logic [2:0] minute_tens_digit;
    logic [3:0] minute_ones_digit;
    logic [2:0] second_tens_digit;
    logic [3:0] second_ones_digit;
  } time_s;

endpackage

// ### rtl/bcd_digit_reg.sv
module bcd_digit_reg #(
  parameter int WIDTH = 4,
  parameter int MAX_VALUE = 9
) (
  input wire logic clock,
  input wire logic ce,
  input wire logic load,
  input wire logic [WIDTH-1:0] value_in,
  output logic legal,
  output logic [WIDTH-1:0] value
);

  localparam logic [WIDTH-1:0] MAX_W = WIDTH'(MAX_VALUE);

  // Range check of the offered digit
  assign legal = (value_in <= MAX_W);

  // Digit storage, left unset by reset
  always_ff @(posedge clock)
  begin
    if (ce && load)
      value <= value_in;
  end

endmodule

// ### rtl/time_view_mux.sv
module time_view_mux (
  input wire logic [rtc_view_pkg::CTRL_PTR_W-1:0] view_pointer,
  input wire rtc_view_pkg::time_s now,
  output logic [rtc_view_pkg::DATA_W-1:0] value
);
  import rtc_view_pkg::*;

  logic [DATA_W-1:0] wdayhr_word;
  logic [DATA_W-1:0] minsec_word;

  // Pack each view, unused bits as zero
  assign wdayhr_word = {5'h00, now.weekday_digit, 2'h0,
                        now.hour_tens_digit, now.hour_ones_digit};
  assign minsec_word = {1'b0, now.minute_tens_digit, now.minute_ones_digit,
                        1'b0, now.second_tens_digit, now.second_ones_digit};

  // Select by pointer; other pointer codes read zero
  assign value = (view_pointer == PTR_WDAYHR) ? wdayhr_word :
                 (view_pointer == PTR_MINSEC) ? minsec_word : 16'h0000;

endmodule

// ### rtl/rtc_time_value_views.sv
// How it works
// - Pointer 01 shows weekday and hour digits in the value window.
// - Pointer 00 shows minute and second digits in the value window.
// - Weekday digit sits in bits 10..8, legal 0 to 6.
// - Hour tens digit sits in bits 5..4, legal 0 to 2.
// - Hour ones digit sits in bits 3..0, legal 0 to 9.
// - Minute tens digit sits in bits 14..12, legal 0 to 5.
// - Minute ones digit sits in bits 11..8, legal 0 to 9.
// - Second tens digit sits in bits 6..4, legal 0 to 5.
// - Second ones digit sits in bits 3..0, legal 0 to 9.
// - Weekday and hours writes taken only while write enable is 1.
// - Bits without a digit read zero and ignore writes.
// - Clock enable control changes only while write enable is 1.
module rtc_time_value_views (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  input wire rtc_view_pkg::reg_req_s req,
  output logic [rtc_view_pkg::DATA_W-1:0] rdata,
  output rtc_view_pkg::time_s time_now,
  output logic clock_write_enable,
  output logic clock_enable_control
);
  import rtc_view_pkg::*;

  // Control state
  logic [CTRL_PTR_W-1:0] view_pointer_r;
  logic [CTRL_PTR_W-1:0] view_pointer_nxt;
  logic wren_r;
  logic wren_nxt;
  logic en_r;
  logic en_nxt;
  logic err_r;
  logic err_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;

  // Decode
  logic wr_ctrl;
  logic wr_value;
  logic rd_ctrl;
  logic rd_value;
  logic view_wdayhr;
  logic view_minsec;
  logic wdayhr_legal;
  logic minsec_legal;
  logic load_wdayhr;
  logic load_minsec;
  logic bad_value_write;
  logic [DATA_W-1:0] ctrl_word;
  logic [DATA_W-1:0] window_word;

  // Per digit wiring
  logic [DIGIT_W-1:0] digit_q [NUM_DIGITS];
  logic [NUM_DIGITS-1:0] digit_legal;
  logic [NUM_DIGITS-1:0] digit_load;

  // Address decode of the register port
  assign wr_ctrl = ce && req.wr && (req.addr == ADDR_CTRL);
  assign wr_value = ce && req.wr && (req.addr == ADDR_VALUE);
  assign rd_ctrl = ce && req.rd && (req.addr == ADDR_CTRL);
  assign rd_value = ce && req.rd && (req.addr == ADDR_VALUE);

  // Which view the window shows
  assign view_wdayhr = (view_pointer_r == PTR_WDAYHR);
  assign view_minsec = (view_pointer_r == PTR_MINSEC);

  // Whole view legal only when every digit in it is legal
  assign wdayhr_legal = &(digit_legal | ~digit_in_view(1'b1));
  assign minsec_legal = &(digit_legal | ~digit_in_view(1'b0));

  // Write acceptance per view
  assign load_wdayhr = wr_value && view_wdayhr && wren_r && wdayhr_legal;
  assign load_minsec = wr_value && view_minsec && wren_r && minsec_legal;

  // Enabled write refused for an out of range digit
  assign bad_value_write = wr_value && wren_r &&
    ((view_wdayhr && !wdayhr_legal) || (view_minsec && !minsec_legal));

  // Mask of digits that belong to one view
  function automatic logic [NUM_DIGITS-1:0] digit_in_view(input logic wh);
    logic [NUM_DIGITS-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_DIGITS; i++)
      m[i] = (DIG_IN_WDAYHR[i] == wh);
    return m;
  endfunction

  // One stored digit per field, placed by the digit table
  for (genvar g = 0; g < NUM_DIGITS; g++)
  begin : g_digit
    logic [DIG_WID[g]-1:0] q;
    assign digit_load[g] = DIG_IN_WDAYHR[g] ? load_wdayhr : load_minsec;
    bcd_digit_reg #(
      .WIDTH(DIG_WID[g]),
      .MAX_VALUE(DIG_MAX[g])
    ) u_digit (
      .clock(clock),
      .ce(ce),
      .load(digit_load[g]),
      .value_in(req.wdata[DIG_LSB[g] +: DIG_WID[g]]),
      .legal(digit_legal[g]),
      .value(q)
    );
    assign digit_q[g] = DIGIT_W'(q);
  end

  // Collect the digits into the time view
  assign time_now.weekday_digit = digit_q[IDX_WEEKDAY_DIGIT][2:0];
  assign time_now.hour_tens_digit = digit_q[IDX_HOUR_TENS_DIGIT][1:0];
  assign time_now.hour_ones_digit = digit_q[IDX_HOUR_ONES_DIGIT];
  assign time_now.minute_tens_digit = digit_q[IDX_MINUTE_TENS_DIGIT][2:0];
  assign time_now.minute_ones_digit = digit_q[IDX_MINUTE_ONES_DIGIT];
  assign time_now.second_tens_digit = digit_q[IDX_SECOND_TENS_DIGIT][2:0];
  assign time_now.second_ones_digit = digit_q[IDX_SECOND_ONES_DIGIT];

  // Window read path, unused bits forced to zero
  time_view_mux u_mux (
    .view_pointer(view_pointer_r),
    .now(time_now),
    .value(window_word)
  );

  // Control readback
  assign ctrl_word = DATA_W'({err_r, en_r, wren_r, view_pointer_r});

  // Control next values
  assign view_pointer_nxt = wr_ctrl ?
    req.wdata[CTRL_PTR_LSB +: CTRL_PTR_W] : view_pointer_r;
  assign wren_nxt = wr_ctrl ? req.wdata[CTRL_WREN_BIT] : wren_r;
  assign en_nxt = (wr_ctrl && wren_r) ? req.wdata[CTRL_EN_BIT] : en_r;

  // Sticky refusal flag, write one to clear, a new refusal wins
  assign err_nxt = bad_value_write ? 1'b1 :
    (wr_ctrl && req.wdata[CTRL_ERR_BIT]) ? 1'b0 : err_r;

  // Read data valid for the one cycle after the strobe
  assign rdata_nxt = rd_value ? window_word :
                     rd_ctrl ? ctrl_word : RDATA_RESET;

  // Control registers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      view_pointer_r <= PTR_RESET;
      wren_r <= WREN_RESET;
      en_r <= EN_RESET;
      err_r <= ERR_RESET;
    end
    else if (ce)
    begin
      view_pointer_r <= view_pointer_nxt;
      wren_r <= wren_nxt;
      en_r <= en_nxt;
      err_r <= err_nxt;
    end
  end

  // Read data register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata_r <= RDATA_RESET;
    else if (ce)
      rdata_r <= rdata_nxt;
  end

  assign rdata = rdata_r;
  assign clock_write_enable = wren_r;
  assign clock_enable_control = en_r;

  // Weekday and hours read shows stored digits
  AST_RD_WDAYHR: assert property (@(posedge clock) disable iff (!rst_n)
    rd_value && view_wdayhr |=>
    rdata == {5'h00, $past(time_now.weekday_digit), 2'h0,
              $past(time_now.hour_tens_digit),
              $past(time_now.hour_ones_digit)})
    else $error("weekday and hours view read wrong");

  // Minutes and seconds read shows stored tens digits, spare bits zero
  AST_RD_MINSEC: assert property (@(posedge clock) disable iff (!rst_n)
    rd_value && view_minsec |=>
    rdata[15] == 1'b0 && rdata[7] == 1'b0 &&
    rdata[14:12] == $past(time_now.minute_tens_digit) &&
    rdata[6:4] == $past(time_now.second_tens_digit))
    else $error("minutes and seconds view read wrong");

  // Out of range weekday never loads and raises the flag
  AST_WEEKDAY_DIGIT_RANGE: assert property (@(posedge clock) disable iff (!rst_n)
    wr_value && wren_r && view_wdayhr && req.wdata[10:8] > 3'h6
    |-> !load_wdayhr ##1 err_r)
    else $error("weekday above six accepted");

  // Legal hour write lands in the hour digits
  AST_HOUR_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
    load_wdayhr |=> time_now.hour_tens_digit == $past(req.wdata[5:4]) &&
    time_now.hour_ones_digit == $past(req.wdata[3:0]))
    else $error("hour digits not taken from bits 5..0");

  // Out of range minute tens refused
  AST_MINUTE_TENS_DIGIT_RANGE: assert property (@(posedge clock) disable iff (!rst_n)
    wr_value && view_minsec && req.wdata[14:12] > 3'h5 |-> !load_minsec)
    else $error("minute tens above five accepted");

  // Legal minutes and seconds write lands in the ones digits
  AST_MINSEC_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
    load_minsec |=> time_now.minute_ones_digit == $past(req.wdata[11:8]) &&
    time_now.second_ones_digit == $past(req.wdata[3:0]))
    else $error("minute or second ones digit not stored");

  // No digit moves without write enable
  AST_WREN_GATE: assert property (@(posedge clock) disable iff (!rst_n)
    wr_value && !wren_r |-> digit_load == '0)
    else $error("value write taken with write enable low");

  // Unused weekday and hours window bits always read zero
  AST_UNUSED_ZERO: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rd_value) && $past(view_wdayhr) |-> rdata[15:11] == 5'h00 &&
    rdata[7:6] == 2'h0)
    else $error("unused weekday and hours bits not zero");

  // Clock enable control holds while write enable is low
  AST_EN_GATE: assert property (@(posedge clock) disable iff (!rst_n)
    !wren_r && ce |=> en_r == $past(en_r))
    else $error("clock enable changed without write enable");

  // Refusal flag set after a refused write, write enable unchanged
  AST_ERR_SET_WINS: assert property (@(posedge clock) disable iff (!rst_n)
    bad_value_write |=> err_r [*1] ##0 clock_write_enable == $past(wren_r))
    else $error("refusal flag lost");

  // Read data stands one cycle only
  AST_RDATA_ONE: assert property (@(posedge clock) disable iff (!rst_n)
    ce && !req.rd |=> rdata == 16'h0000)
    else $error("read data held past its cycle");

endmodule

// ### sim/rtc_time_value_views_test.sv
module rtc_time_value_views_test;
  timeunit 1ns;
  timeprecision 100ps;
  import rtc_view_pkg::*;

  logic clock;
  logic rst_n;
  logic ce;
  reg_req_s req;
  logic [DATA_W-1:0] rdata;
  time_s time_now;
  logic clock_write_enable;
  logic clock_enable_control;
  int error_cnt;
  int n_tests;

  rtc_time_value_views dut_u (
    .clock(clock),
    .rst_n(rst_n),
    .ce(ce),
    .req(req),
    .rdata(rdata),
    .time_now(time_now),
    .clock_write_enable(clock_write_enable),
    .clock_enable_control(clock_enable_control)
  );

  // Free-running 20 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Compare one result word
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clock);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clock);
    req.wr <= 1'b0;
  endtask

  // One-cycle read strobe, data judged in the following cycle
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
    @(posedge clock);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clock);
    req.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Reset state, unmapped address and idle read data
  task automatic t_reset();
    rd(ADDR_CTRL, 16'h0000);
    rd(4'h7, 16'h0000);
    wr(4'h7, 16'hffff);
    rd(ADDR_CTRL, 16'h0000);
    @(posedge clock);
    #1;
    chk(rdata, 16'h0000);
    $display("reset test done");
  endtask

  // Enable control gated by the stored write enable
  task automatic t_enable();
    wr(ADDR_CTRL, 16'h0008);
    rd(ADDR_CTRL, 16'h0000);
    wr(ADDR_CTRL, 16'h000c);
    rd(ADDR_CTRL, 16'h0004);
    wr(ADDR_CTRL, 16'h000c);
    rd(ADDR_CTRL, 16'h000c);
    chk({14'h0, clock_enable_control, clock_write_enable}, 16'h3);
    wr(ADDR_CTRL, 16'h0004);
    rd(ADDR_CTRL, 16'h0004);
    $display("enable test done");
  endtask

  // Field placement in both views, spare bits dropped
  task automatic t_fields();
    wr(ADDR_CTRL, 16'h0005);
    wr(ADDR_VALUE, 16'hf8e3);
    rd(ADDR_VALUE, 16'h0023);
    wr(ADDR_VALUE, 16'h0629);
    rd(ADDR_VALUE, 16'h0629);
    chk(16'(time_now.weekday_digit), 16'h0006);
    chk(16'({time_now.hour_tens_digit, time_now.hour_ones_digit}),
        16'h0029);
    wr(ADDR_CTRL, 16'h0004);
    wr(ADDR_VALUE, 16'hd9d9);
    rd(ADDR_VALUE, 16'h5959);
    chk(16'({time_now.minute_tens_digit, time_now.minute_ones_digit, 1'b0,
             time_now.second_tens_digit, time_now.second_ones_digit}),
        16'h5959);
    wr(ADDR_VALUE, 16'h0000);
    rd(ADDR_VALUE, 16'h0000);
    $display("field test done");
  endtask

  // Value writes ignored while write enable is clear
  task automatic t_gate();
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_VALUE, 16'h1234);
    rd(ADDR_VALUE, 16'h0000);
    wr(ADDR_CTRL, 16'h0001);
    wr(ADDR_VALUE, 16'h0100);
    rd(ADDR_VALUE, 16'h0629);
    $display("gate test done");
  endtask

  // Each digit one above its range is refused whole
  task automatic t_illegal();
    logic [15:0] bad;
    logic [15:0] old;
    logic [15:0] ptr;
    for (int i = 0; i < NUM_DIGITS; i++)
    begin
      ptr = DIG_IN_WDAYHR[i] ? 16'h0005 : 16'h0004;
      old = DIG_IN_WDAYHR[i] ? 16'h0629 : 16'h0000;
      bad = 16'(DIG_MAX[i] + 1) << DIG_LSB[i];
      wr(ADDR_CTRL, ptr);
      wr(ADDR_VALUE, bad);
      rd(ADDR_VALUE, old);
      rd(ADDR_CTRL, ptr | 16'h0010);
      wr(ADDR_CTRL, ptr | 16'h0010);
      rd(ADDR_CTRL, ptr);
    end
    $display("range test done");
  endtask

  // Other pointer codes read zero and take no writes
  task automatic t_pointer();
    for (int p = 2; p < 4; p++)
    begin
      wr(ADDR_CTRL, 16'h0004 | 16'(p));
      wr(ADDR_VALUE, 16'h1234);
      rd(ADDR_VALUE, 16'h0000);
    end
    wr(ADDR_CTRL, 16'h0004);
    rd(ADDR_VALUE, 16'h0000);
    wr(ADDR_CTRL, 16'h0005);
    rd(ADDR_VALUE, 16'h0629);
    $display("pointer test done");
  endtask

  // Control write strobe ignored while the clock enable is low
  task automatic t_ce();
    @(posedge clock);
    ce <= 1'b0;
    wr(ADDR_CTRL, 16'h0000);
    ce <= 1'b1;
    rd(ADDR_CTRL, 16'h0005);
    $display("clock enable test done");
  endtask

  // Mid-run reset clears control and read data, digits are kept
  task automatic t_rst();
    wr(ADDR_CTRL, 16'h000c);
    rd(ADDR_CTRL, 16'h000c);
    @(posedge clock);
    rst_n <= 1'b0;
    @(posedge clock);
    #1;
    chk({14'h0, clock_enable_control, clock_write_enable}, 16'h0);
    chk(rdata, 16'h0000);
    @(posedge clock);
    rst_n <= 1'b1;
    rd(ADDR_CTRL, 16'h0000);
    wr(ADDR_CTRL, 16'h0001);
    rd(ADDR_VALUE, 16'h0629);
    $display("second reset test done");
  endtask

  // Guard against a hang
  initial
  begin
    #2000000;
    error_cnt++;
    complete_run();
  end

  // Main sequence
  initial
  begin
    error_cnt = 0;
    n_tests = 0;
    rst_n = 1'b0;
    ce = 1'b1;
    req = '0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_enable();
    t_fields();
    t_gate();
    t_illegal();
    t_pointer();
    t_ce();
    t_rst();
    complete_run();
  end
endmodule
